// ==== include/acc_defs.vh ====
// Purpose: constants for the conversion control block
// Assumes: byte-wide registers on a plain strobe port
// Notes: offsets are word addresses on the local port
`ifndef ACC_DEFS_VH
`define ACC_DEFS_VH
// register offsets
`define ACC_ADDR_CTRL_STATUS 3'h0
`define ACC_ADDR_CTRL2 3'h1
`define ACC_ADDR_RESULT_HIGH 3'h2
`define ACC_ADDR_RESULT_LOW 3'h3
`define ACC_ADDR_COMPARE_HIGH 3'h4
`define ACC_ADDR_COMPARE_LOW 3'h5
`define ACC_ADDR_IRQ_STATUS 3'h6
`define ACC_ADDR_IRQ_ENABLE 3'h7
// a write to irq status clears the written ones
// control/status fields
`define ACC_BIT_DONE 7
`define ACC_BIT_IRQ_EN 6
`define ACC_BIT_CONT 5
`define ACC_CHAN_MSB 4
`define ACC_CHAN_LSB 0
// control 2 fields
`define ACC_BIT_ACTIVE 7
`define ACC_BIT_TRIG_SEL 6
`define ACC_BIT_CMP_EN 5
`define ACC_BIT_CMP_DIR 4
// channel codes
`define ACC_CHAN_OFF 5'h1f
`define ACC_CHAN_RSVD 5'h1c
`define ACC_CHAN_REF_HIGH 5'h1d
`define ACC_CHAN_REF_LOW 5'h1e
`define ACC_CHAN_LAST_INPUT 5'h1b
// reset values
`define ACC_RST_CTRL_STATUS 8'h1f
`define ACC_RST_CTRL2 8'h00
// timing
`define ACC_CONV_TIME_NS 2500
`define ACC_CLK_PERIOD_NS 100
`define ACC_CONV_CYCLES ((`ACC_CONV_TIME_NS + `ACC_CLK_PERIOD_NS - 1) / `ACC_CLK_PERIOD_NS)
// irq status bits
`define ACC_IRQ_DONE 0
`define ACC_IRQ_ABORT 1
`endif

// ==== core/acc_chan_decode.v ====
// Purpose: decode the channel selector into a one-hot input select
// Assumes: select code is stable while a conversion runs
// Notes: reserved and off codes connect nothing
`timescale 1ns/1ps
`include "acc_defs.vh"
module acc_chan_decode #(
  parameter NUM_INPUTS = 28
)
(
  input wire [4:0] chan_in,
  output wire [NUM_INPUTS-1:0] input_sel_out,
  output wire ref_high_sel_out,
  output wire ref_low_sel_out,
  output wire powered_out
);
  genvar gi;
  // one select line per analog input
  generate
    for (gi = 0; gi < NUM_INPUTS; gi = gi + 1)
    begin : g_sel
      assign input_sel_out[gi] = (chan_in == gi[4:0]);
    end
  endgenerate
  // references and power down
  assign ref_high_sel_out = (chan_in == `ACC_CHAN_REF_HIGH);
  assign ref_low_sel_out = (chan_in == `ACC_CHAN_REF_LOW);
  assign powered_out = (chan_in != `ACC_CHAN_OFF);
endmodule // acc_chan_decode

// ==== core/acc_sar.v ====
// Purpose: successive-approximation sequencer, one bit per enable
// Assumes: comparator input is sampled each step
// Notes: abort returns to idle at once unless start comes in the same cycle
`timescale 1ns/1ps
`include "acc_defs.vh"
module acc_sar #(
  parameter WIDTH = 12
)
(
  input wire clk_in,
  input wire reset_in,
  input wire start_in,
  input wire abort_in,
  input wire step_in,
  input wire comp_hi_in,
  output reg busy_out,
  output reg done_out,
  output reg [WIDTH-1:0] result_out,
  output wire [WIDTH-1:0] trial_out
);
  reg [WIDTH-1:0] mask_ff;
  reg [WIDTH-1:0] acc_ff;
  assign trial_out = acc_ff | mask_ff;
  // bit walk from msb to lsb
  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      mask_ff <= {WIDTH{1'b0}};
      acc_ff <= {WIDTH{1'b0}};
      busy_out <= 1'b0;
      done_out <= 1'b0;
      result_out <= {WIDTH{1'b0}};
    end
    else
    begin
      done_out <= 1'b0;
      if (abort_in)
      begin
        busy_out <= 1'b0;
        mask_ff <= {WIDTH{1'b0}};
      end
      if (start_in)
      begin
        busy_out <= 1'b1;
        acc_ff <= {WIDTH{1'b0}};
        mask_ff <= {1'b1, {(WIDTH-1){1'b0}}};
      end
      else if (busy_out && !abort_in && step_in)
      begin
        if (comp_hi_in)
          acc_ff <= acc_ff | mask_ff;
        mask_ff <= mask_ff >> 1;
        if (mask_ff[0])
        begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
          result_out <= comp_hi_in ? (acc_ff | mask_ff) : acc_ff;
        end
      end
    end
  end
endmodule // acc_sar

// ==== core/acc_conv_ctrl.v ====
// Purpose: control and status for a 12-bit sar converter
// Assumes: one 10 MHz clock, trigger input synchronous
// Notes: register port with read data one cycle after strobe
`timescale 1ns/1ps
`include "acc_defs.vh"
// Contract
// - control write aborts, restarts in software trigger mode unless channel off
// - compare off: every completion sets done except one in a control write cycle
// - compare on: done only if compare true
// - control write or low result read clears
// - done with irq enable raises interrupt
// - single mode: one conversion per trigger
// - continuous mode repeats after its start
// - all-ones channel powers converter off
// - stop by off code: no extra conversion
// - single mode idles after completion
// - channel codes: inputs, reserved, references
// - trigger select: software or hardware start
// - active flag set on start, cleared end
// - compare less-than or greater-equal by direction
module acc_conv_ctrl #(
  parameter WIDTH = 12,
  parameter NUM_INPUTS = 28,
  parameter CONV_CYCLES = `ACC_CONV_CYCLES
)
(
  input wire clk_in,
  input wire reset_in,
  input wire [2:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire hardware_trigger_input_in,
  input wire comp_hi_in,
  output reg [7:0] rdata_out,
  output reg irq_out,
  output reg conversion_active_out,
  output reg converter_power_out,
  output reg [NUM_INPUTS-1:0] input_sel_out,
  output reg ref_high_sel_out,
  output reg ref_low_sel_out,
  output reg [WIDTH-1:0] dac_trial_out
);
  localparam ST_IDLE = 2'h0;
  localparam ST_CONV = 2'h1;
  localparam ST_CONT = 2'h2;
  localparam STEP_DIV = (CONV_CYCLES + WIDTH - 1) / WIDTH;
  localparam DIV_W = 8;

  // software-visible state
  reg conversion_done_flag_ff;
  reg done_irq_enable_ff;
  reg continuous_enable_ff;
  reg [4:0] channel_selector_ff;
  reg trigger_source_select_ff;
  reg compare_function_enable_ff;
  reg compare_direction_select_ff;
  reg [WIDTH-1:0] result_ff;
  reg [WIDTH-1:0] compare_value_ff;
  reg [1:0] irq_status_ff;
  reg [1:0] irq_enable_ff;
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg trig_prev_ff;
  reg [DIV_W-1:0] div_ff;

  wire wr_ctrl;
  wire rd_low;
  wire off_code;
  wire hw_edge;
  wire start_conv;
  wire abort_conv;
  wire step;
  wire sar_busy;
  wire sar_done;
  wire [WIDTH-1:0] sar_result;
  wire [WIDTH-1:0] sar_trial;
  wire cmp_true;
  wire done_set;
  wire [NUM_INPUTS-1:0] dec_sel;
  wire dec_ref_high;
  wire dec_ref_low;
  wire dec_powered;
  wire irq_clr_done;

  assign wr_ctrl = wr_in && (addr_in == `ACC_ADDR_CTRL_STATUS);
  assign rd_low = rd_in && (addr_in == `ACC_ADDR_RESULT_LOW);
  assign off_code = (wdata_in[`ACC_CHAN_MSB:`ACC_CHAN_LSB] == `ACC_CHAN_OFF);
  assign hw_edge = hardware_trigger_input_in && !trig_prev_ff;

  // start sources: control write in software mode, trigger edge in hardware mode
  // bit 6 of a control write is the irq enable, so only the stored trigger select gates a software start
  assign start_conv = (wr_ctrl && !off_code && !trigger_source_select_ff)
    || (!wr_ctrl && trigger_source_select_ff && hw_edge && state_ff == ST_IDLE
        && channel_selector_ff != `ACC_CHAN_OFF)
    || (!wr_ctrl && state_ff == ST_CONT && !sar_busy && !sar_done);
  assign abort_conv = wr_ctrl;

  // step enable divider spreads the bits over the conversion time
  assign step = (div_ff == (STEP_DIV[DIV_W-1:0] - 8'h01));
  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      div_ff <= 8'h00;
    else if (start_conv || step)
      div_ff <= 8'h00;
    else
      div_ff <= div_ff + 8'h01;
  end

  acc_sar #(
    .WIDTH(WIDTH)
  ) u_sar (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .start_in(start_conv),
    .abort_in(abort_conv),
    .step_in(step),
    .comp_hi_in(comp_hi_in),
    .busy_out(sar_busy),
    .done_out(sar_done),
    .result_out(sar_result),
    .trial_out(sar_trial)
  );

  acc_chan_decode #(
    .NUM_INPUTS(NUM_INPUTS)
  ) u_dec (
    .chan_in(channel_selector_ff),
    .input_sel_out(dec_sel),
    .ref_high_sel_out(dec_ref_high),
    .ref_low_sel_out(dec_ref_low),
    .powered_out(dec_powered)
  );

  // compare direction picks less-than or greater-or-equal
  assign cmp_true = compare_direction_select_ff ? (sar_result >= compare_value_ff)
    : (sar_result < compare_value_ff);
  assign done_set = sar_done && !wr_ctrl && (!compare_function_enable_ff || cmp_true);

  // sequencing state
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (start_conv)
          nxt_state = continuous_enable_ff ? ST_CONT : ST_CONV;
      end
      ST_CONV:
      begin
        if (sar_done)
          nxt_state = ST_IDLE;
      end
      ST_CONT:
      begin
        if (!continuous_enable_ff)
          nxt_state = ST_IDLE;
      end
      default:
        nxt_state = ST_IDLE;
    endcase
    if (wr_ctrl)
    begin
      if (off_code)
        nxt_state = ST_IDLE;
      else if (start_conv)
        nxt_state = wdata_in[`ACC_BIT_CONT] ? ST_CONT : ST_CONV;
      else
        nxt_state = ST_IDLE;
    end
  end

  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state_ff <= ST_IDLE;
      trig_prev_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      trig_prev_ff <= hardware_trigger_input_in;
    end
  end

  // register writes and flag updates
  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      conversion_done_flag_ff <= 1'b0;
      done_irq_enable_ff <= 1'b0;
      continuous_enable_ff <= 1'b0;
      channel_selector_ff <= `ACC_CHAN_OFF;
      trigger_source_select_ff <= 1'b0;
      compare_function_enable_ff <= 1'b0;
      compare_direction_select_ff <= 1'b0;
      result_ff <= {WIDTH{1'b0}};
      compare_value_ff <= {WIDTH{1'b0}};
    end
    else
    begin
      if (wr_ctrl)
      begin
        done_irq_enable_ff <= wdata_in[`ACC_BIT_IRQ_EN];
        continuous_enable_ff <= wdata_in[`ACC_BIT_CONT];
        channel_selector_ff <= wdata_in[`ACC_CHAN_MSB:`ACC_CHAN_LSB];
      end
      if (wr_in && addr_in == `ACC_ADDR_CTRL2)
      begin
        trigger_source_select_ff <= wdata_in[`ACC_BIT_TRIG_SEL];
        compare_function_enable_ff <= wdata_in[`ACC_BIT_CMP_EN];
        compare_direction_select_ff <= wdata_in[`ACC_BIT_CMP_DIR];
      end
      if (wr_in && addr_in == `ACC_ADDR_COMPARE_HIGH)
        compare_value_ff[WIDTH-1:8] <= wdata_in[WIDTH-9:0];
      if (wr_in && addr_in == `ACC_ADDR_COMPARE_LOW)
        compare_value_ff[7:0] <= wdata_in;
      if (done_set)
        result_ff <= sar_result;
      // set wins over a low result read; a control write clears
      if (done_set)
        conversion_done_flag_ff <= 1'b1;
      else if (wr_ctrl || rd_low)
        conversion_done_flag_ff <= 1'b0;
    end
  end

  // sticky event status: done and abort
  assign irq_clr_done = wr_in && addr_in == `ACC_ADDR_IRQ_STATUS;
  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      irq_status_ff <= 2'h0;
      irq_enable_ff <= 2'h0;
    end
    else
    begin
      irq_status_ff[`ACC_IRQ_DONE] <= done_set
        || (irq_status_ff[`ACC_IRQ_DONE] && !(irq_clr_done && wdata_in[`ACC_IRQ_DONE]));
      irq_status_ff[`ACC_IRQ_ABORT] <= (wr_ctrl && sar_busy)
        || (irq_status_ff[`ACC_IRQ_ABORT] && !(irq_clr_done && wdata_in[`ACC_IRQ_ABORT]));
      if (wr_in && addr_in == `ACC_ADDR_IRQ_ENABLE)
        irq_enable_ff <= wdata_in[1:0];
    end
  end

  // registered outputs and read data
  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      rdata_out <= 8'h00;
      irq_out <= 1'b0;
      conversion_active_out <= 1'b0;
      converter_power_out <= 1'b0;
      input_sel_out <= {NUM_INPUTS{1'b0}};
      ref_high_sel_out <= 1'b0;
      ref_low_sel_out <= 1'b0;
      dac_trial_out <= {WIDTH{1'b0}};
    end
    else
    begin
      irq_out <= (conversion_done_flag_ff && done_irq_enable_ff)
        || |(irq_status_ff & irq_enable_ff);
      conversion_active_out <= sar_busy;
      // power only while selected and running
      converter_power_out <= dec_powered && (sar_busy || state_ff == ST_CONT);
      input_sel_out <= dec_powered ? dec_sel : {NUM_INPUTS{1'b0}};
      ref_high_sel_out <= dec_ref_high;
      ref_low_sel_out <= dec_ref_low;
      dac_trial_out <= sar_trial;
      rdata_out <= 8'h00;
      if (rd_in)
      begin
        case (addr_in)
          `ACC_ADDR_CTRL_STATUS:
            rdata_out <= {conversion_done_flag_ff, done_irq_enable_ff, continuous_enable_ff, channel_selector_ff};
          `ACC_ADDR_CTRL2:
            rdata_out <= {sar_busy, trigger_source_select_ff, compare_function_enable_ff,
              compare_direction_select_ff, 4'h0};
          `ACC_ADDR_RESULT_HIGH:
            rdata_out <= {{(16-WIDTH){1'b0}}, result_ff[WIDTH-1:8]};
          `ACC_ADDR_RESULT_LOW:
            rdata_out <= result_ff[7:0];
          `ACC_ADDR_COMPARE_HIGH:
            rdata_out <= {{(16-WIDTH){1'b0}}, compare_value_ff[WIDTH-1:8]};
          `ACC_ADDR_COMPARE_LOW:
            rdata_out <= compare_value_ff[7:0];
          `ACC_ADDR_IRQ_STATUS:
            rdata_out <= {6'h00, irq_status_ff};
          `ACC_ADDR_IRQ_ENABLE:
            rdata_out <= {6'h00, irq_enable_ff};
          default:
            rdata_out <= 8'h00;
        endcase
      end
    end
  end
endmodule // acc_conv_ctrl

// ==== dv/acc_asserts.sv ====
// Purpose: port checks for the conversion control block
// Assumes: one clock, reset async active high
// Notes: bound to the block at file end
`timescale 1ns/1ps
module acc_asserts #(
  parameter NUM_INPUTS = 28
)
(
  input wire clk_in,
  input wire reset_in,
  input wire [2:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire [7:0] rdata_out,
  input wire conversion_active_out,
  input wire converter_power_out,
  input wire [NUM_INPUTS-1:0] input_sel_out,
  input wire ref_high_sel_out,
  input wire ref_low_sel_out
);
  // off code written to control/status
  wire off_wr = wr_in && addr_in == 3'h0 && wdata_in[4:0] == 5'h1f;
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // channel decode and isolation
  chk_sel_onehot: assert property ($onehot0(input_sel_out))
    else $error("input select not one-hot");
  chk_ref_exclusive: assert property (ref_high_sel_out |-> !ref_low_sel_out && input_sel_out == 0)
    else $error("reference select overlaps");
  chk_off_isolate: assert property (off_wr |-> ##3 input_sel_out == 0 && !ref_high_sel_out && !ref_low_sel_out)
    else $error("off code leaves a source selected");
  chk_off_power: assert property (off_wr |-> ##3 !converter_power_out)
    else $error("off code leaves converter powered");
  chk_off_no_conv: assert property (off_wr |-> ##3 (!conversion_active_out) [*6])
    else $error("conversion after off code");
  chk_power_active: assert property (conversion_active_out |-> converter_power_out)
    else $error("active while unpowered");
  chk_write_clears_done: assert property (wr_in && addr_in == 3'h0 ##1 rd_in && addr_in == 3'h0
    |-> ##1 !rdata_out[7])
    else $error("done seen after control write");
  chk_rdata_one_cycle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data outside its cycle");
endmodule // acc_asserts

bind acc_conv_ctrl acc_asserts #(.NUM_INPUTS(NUM_INPUTS)) u_chk (
  .clk_in(clk_in),
  .reset_in(reset_in),
  .addr_in(addr_in),
  .wdata_in(wdata_in),
  .wr_in(wr_in),
  .rd_in(rd_in),
  .rdata_out(rdata_out),
  .conversion_active_out(conversion_active_out),
  .converter_power_out(converter_power_out),
  .input_sel_out(input_sel_out),
  .ref_high_sel_out(ref_high_sel_out),
  .ref_low_sel_out(ref_low_sel_out)
);

// ==== dv/adc_conversion_control_tb.sv ====
// Purpose: self-checking bench for the conversion control block
// Assumes: comparator high keeps every bit, so result is 0xfff
// Notes: one task per scenario
`timescale 1ns/1ps
`include "acc_defs.vh"
module adc_conversion_control_tb;
  reg clk_in = 1'b0;
  reg reset_in = 1'b1;
  reg [2:0] addr_in = 3'h0;
  reg [7:0] wdata_in = 8'h00;
  reg wr_in = 1'b0;
  reg rd_in = 1'b0;
  reg hw_in = 1'b0;
  reg comp_hi_in = 1'b1;
  wire [7:0] rdata_out;
  wire irq;
  wire act;
  wire pwr;
  wire [27:0] sel;
  wire rh;
  wire rl;
  integer err_count = 0;
  integer comparisons = 0;
  integer cycles = 0;
  integer i;
  integer j;
  reg [7:0] d;
  acc_conv_ctrl DUT (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .hardware_trigger_input_in(hw_in),
    .comp_hi_in(comp_hi_in),
    .rdata_out(rdata_out),
    .irq_out(irq),
    .conversion_active_out(act),
    .converter_power_out(pwr),
    .input_sel_out(sel),
    .ref_high_sel_out(rh),
    .ref_low_sel_out(rl),
    .dac_trial_out()
  );
  // clock, and a ceiling on run length
  always #50 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      err_count = err_count + 1;
      end_sim;
    end
  end
  // compare and count
  task chk(input [8*6-1:0] what, input [31:0] seen, input [31:0] exp);
  begin
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      err_count = err_count + 1;
      $display("[FAIL] %0s expected %h seen %h", what, exp, seen);
    end
  end
  endtask
  // register bus cycles
  task wr(input [2:0] a, input [7:0] v);
  begin
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  end
  endtask
  task rd(input [2:0] a);
  begin
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  end
  endtask
  task cyc(input integer n);
  begin
    repeat (n) @(posedge clk_in);
    #1;
  end
  endtask
  // wait for the conversion to end, bounded
  task idle;
  begin
    cyc(3);
    i = 0;
    while (act !== 1'b0 && i < 100)
    begin
      @(posedge clk_in);
      i = i + 1;
    end
    cyc(3);
    chk("act", act, 0);
  end
  endtask
  // single software conversions on the high reference, then the low reference
  task t_single;
  begin
    wr(3'h0, 8'h1d);
    cyc(2);
    chk("rh", rh, 1);
    rd(3'h1);
    chk("ctrl2", d, 8'h80);
    idle;
    chk("pwr", pwr, 0);
    rd(3'h0);
    chk("ctrl", d, 8'h9d);
    // write then read with no gap: done must read back cleared
    @(posedge clk_in);
    addr_in <= 3'h0;
    wdata_in <= 8'h1f;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk("ctrl", rdata_out, 8'h1f);
    rd(3'h3);
    chk("res lo", d, 8'hff);
    rd(3'h2);
    chk("res hi", d, 8'h0f);
    rd(3'h0);
    chk("ctrl", d, 8'h1f);
    cyc(40);
    chk("act", act, 0);
    wr(3'h0, 8'h1e);
    cyc(2);
    chk("rl", rl, 1);
    idle;
    $display("single done");
  end
  endtask
  // restart by write, then abort by off code
  task t_abort;
  begin
    wr(3'h0, 8'h05);
    cyc(20);
    wr(3'h0, 8'h06);
    cyc(25);
    chk("act", act, 1);
    idle;
    rd(3'h0);
    chk("ctrl", d, 8'h86);
    wr(3'h6, 8'hff);
    wr(3'h0, 8'h05);
    cyc(10);
    wr(3'h0, 8'h1f);
    cyc(40);
    rd(3'h0);
    chk("ctrl", d, 8'h1f);
    rd(3'h6);
    chk("irq st", d, 8'h02);
    $display("abort done");
  end
  endtask
  // continuous run, ended by off code
  task t_cont;
  begin
    wr(3'h0, 8'h25);
    cyc(60);
    rd(3'h3);
    cyc(50);
    rd(3'h0);
    chk("ctrl", d, 8'ha5);
    wr(3'h0, 8'h3f);
    cyc(50);
    chk("act", act, 0);
    chk("pwr", pwr, 0);
    $display("cont done");
  end
  endtask
  // compare at the boundary value 0xfff
  task t_cmp;
  begin
    wr(3'h4, 8'h0f);
    wr(3'h5, 8'hff);
    for (j = 0; j < 3; j = j + 1)
    begin
      wr(3'h1, j == 1 ? 8'h30 : 8'h20);
      comp_hi_in <= j != 0;
      wr(3'h0, 8'h05);
      idle;
      rd(3'h0);
      chk("ctrl", d, j == 2 ? 8'h05 : 8'h85);
      rd(3'h3);
      chk("res lo", d, j == 0 ? 8'h00 : 8'hff);
    end
    comp_hi_in <= 1'b1;
    wr(3'h1, 8'h00);
    $display("compare done");
  end
  endtask
  // interrupt masked, raised, cleared
  task t_irq;
  begin
    wr(3'h6, 8'hff);
    wr(3'h7, 8'h00);
    wr(3'h0, 8'h05);
    cyc(2);
    chk("sel", sel, 28'h20);
    idle;
    chk("irq", irq, 0);
    wr(3'h7, 8'h01);
    cyc(2);
    chk("irq", irq, 1);
    wr(3'h6, 8'h01);
    wr(3'h7, 8'h00);
    cyc(2);
    chk("irq", irq, 0);
    wr(3'h0, 8'h45);
    idle;
    chk("irq", irq, 1);
    rd(3'h3);
    cyc(2);
    chk("irq", irq, 0);
    $display("irq done");
  end
  endtask
  // hardware trigger start
  task t_hw;
  begin
    wr(3'h1, 8'h40);
    wr(3'h0, 8'h05);
    cyc(5);
    chk("act", act, 0);
    @(posedge clk_in);
    hw_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    hw_in <= 1'b0;
    cyc(5);
    chk("act", act, 1);
    idle;
    rd(3'h0);
    chk("ctrl", d, 8'h85);
    cyc(40);
    chk("act", act, 0);
    $display("hw done");
  end
  endtask
  // verdict and end of run
  task end_sim;
  begin
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask
  // main sequence
  initial
  begin
    repeat (20) @(posedge clk_in);
    reset_in <= 1'b0;
    rd(3'h0);
    chk("ctrl", d, `ACC_RST_CTRL_STATUS);
    rd(3'h1);
    chk("ctrl2", d, `ACC_RST_CTRL2);
    t_single;
    t_abort;
    t_cont;
    t_cmp;
    t_irq;
    t_hw;
    end_sim;
  end
endmodule // adc_conversion_control_tb
